// ==== src/gtc_defines.svh ====
`ifndef GTC_DEFINES_SVH
`define GTC_DEFINES_SVH

`define GTC_ADDR_W 12
`define GTC_OFF_CTRL 12'h000
`define GTC_OFF_GATE 12'h004
`define GTC_OFF_CNT_LO 12'h008
`define GTC_OFF_CNT_HI 12'h00c
`define GTC_OFF_STAT 12'h010

// timer control register fields
`define GTC_CTRL_RUN 0
`define GTC_CTRL_SYNC_DIS 2
`define GTC_CTRL_OSC_EN 3
`define GTC_CTRL_PS_LO 4
`define GTC_CTRL_CS_LO 6
// gate control register fields
`define GTC_GATE_VAL 2
`define GTC_GATE_POL 6
`define GTC_GATE_EN 7
// status register fields
`define GTC_STAT_OVF 0

`define GTC_CTRL_RST 8'h00
`define GTC_GATE_RST 8'h00
`define GTC_CNT_RST 16'h0000
`define GTC_CNT_MAX 16'hffff
// system clocks per instruction cycle
`define GTC_INSTR_DIV 4
`define GTC_PHASE_LAST 2'h3
`define GTC_NSYNC 4

`endif

// ==== src/gtc_pkg.sv ====
package gtc_pkg;

   typedef enum logic [1:0] {
      GTC_SRC_INSTR,
      GTC_SRC_SYS,
      GTC_SRC_EXT,
      GTC_SRC_CPS
   } gtc_src_t;

   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
   } gtc_sync_t;

   typedef struct packed {
      logic [2:0] cnt;
   } gtc_pre_t;

   typedef struct packed {
      logic run;
      logic gate_en;
      logic gate_pol;
      logic sync_dis;
      logic osc_en;
      logic [1:0] ps;
      gtc_src_t cs;
      logic [15:0] cnt;
      logic ovf;
      logic armed;
      logic ext_prev;
      logic [1:0] phase;
      logic pend;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic wake;
      logic xout;
   } gtc_state_t;

endpackage

// ==== src/gtc_sync.sv ====
`timescale 1ns/1ps
`include "gtc_defines.svh"
// two-flop synchronizer for the pin-side levels
module gtc_sync (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic [`GTC_NSYNC-1:0] i_d,
   output logic [`GTC_NSYNC-1:0] o_q
);
   gtc_pkg::gtc_sync_t st_r;
   gtc_pkg::gtc_sync_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (i_ce) begin
         st_nxt.s1 = i_d;
         st_nxt.s2 = st_r.s1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_q = st_r.s2;
endmodule

// ==== src/gtc_prescale.sv ====
`timescale 1ns/1ps
`include "gtc_defines.svh"
// hidden divide-by-1/2/4/8 stage ahead of the counter
module gtc_prescale (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_tick,
   input wire logic i_clear,
   input wire logic [1:0] i_ps,
   output logic o_tick
);
   gtc_pkg::gtc_pre_t st_r;
   gtc_pkg::gtc_pre_t st_nxt;
   logic [2:0] mask;

   always_comb begin
      case (i_ps)
         2'h0: mask = 3'h0;
         2'h1: mask = 3'h1;
         2'h2: mask = 3'h3;
         default: mask = 3'h7;
      endcase
   end

   assign o_tick = i_tick && ((st_r.cnt & mask) == mask);

   always_comb begin
      st_nxt = st_r;
      if (i_clear) begin
         st_nxt.cnt = 3'h0;
      end else if (i_tick) begin
         st_nxt.cnt = 3'(st_r.cnt + 3'h1);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= '0;
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   a_clear_zero:
   assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_ce && i_clear) |=> (st_r.cnt == 3'h0))
   else $error("prescaler not cleared by count write");
endmodule

// ==== src/gtc_timer.sv ====
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "gtc_defines.svh"
module gtc_timer (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`GTC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic i_ext_clock_pin,
   input wire logic i_cps_osc,
   input wire logic i_crystal_in_pin,
   input wire logic i_gate_input,
   input wire logic i_sleep,
   output logic o_crystal_out_pin,
   output logic o_crystal_osc_on,
   output logic o_overflow_flag,
   output logic o_wake,
   output logic [15:0] o_count
);
   gtc_pkg::gtc_state_t st_r;
   gtc_pkg::gtc_state_t st_nxt;

   logic [`GTC_NSYNC-1:0] pins_s;
   logic pin_s;
   logic cps_s;
   logic xin_s;
   logic gate_s;

   // all pin levels pass two flops before anything looks at them
   gtc_sync u_sync (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_d({i_gate_input, i_crystal_in_pin, i_cps_osc, i_ext_clock_pin}),
      .o_q(pins_s)
   );
   assign pin_s = pins_s[0];
   assign cps_s = pins_s[1];
   assign xin_s = pins_s[2];
   assign gate_s = pins_s[3];

   // apb decode; one wait state, answer in the second access cycle
   logic acc;
   logic wr_acc;
   logic wr_lo;
   logic wr_hi;
   logic cnt_wr;
   logic mapped;
   logic [31:0] rd_val;

   assign acc = psel && penable && st_r.pready;
   assign wr_acc = acc && pwrite;
   assign wr_lo = wr_acc && (paddr == `GTC_OFF_CNT_LO);
   assign wr_hi = wr_acc && (paddr == `GTC_OFF_CNT_HI);
   assign cnt_wr = wr_lo || wr_hi;

   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0;
      case (paddr)
         `GTC_OFF_CTRL: begin
            rd_val[`GTC_CTRL_RUN] = st_r.run;
            rd_val[`GTC_CTRL_SYNC_DIS] = st_r.sync_dis;
            rd_val[`GTC_CTRL_OSC_EN] = st_r.osc_en;
            rd_val[`GTC_CTRL_PS_LO +: 2] = st_r.ps;
            rd_val[`GTC_CTRL_CS_LO +: 2] = st_r.cs;
         end
         `GTC_OFF_GATE: begin
            // raw synchronized level, readable even with the gate disabled
            rd_val[`GTC_GATE_VAL] = gate_s;
            rd_val[`GTC_GATE_POL] = st_r.gate_pol;
            rd_val[`GTC_GATE_EN] = st_r.gate_en;
         end
         `GTC_OFF_CNT_LO: rd_val[7:0] = st_r.cnt[7:0];
         `GTC_OFF_CNT_HI: rd_val[7:0] = st_r.cnt[15:8];
         `GTC_OFF_STAT: rd_val[`GTC_STAT_OVF] = st_r.ovf;
         default: mapped = 1'b0;
      endcase
   end

   // clock source and edge handling
   logic ext_sel;
   logic ext_lvl;
   logic ext_rise;
   logic ext_fall;
   logic ext_event;
   logic phase_end;
   logic src_tick;
   logic gate_ok;
   logic cnt_en;
   logic sleep_ok;
   logic pre_in;
   logic inc;

   assign ext_sel = (st_r.cs == gtc_pkg::GTC_SRC_EXT) || (st_r.cs == gtc_pkg::GTC_SRC_CPS);
   // pin or crystal by oscillator enable, else sensing oscillator
   assign ext_lvl = (st_r.cs == gtc_pkg::GTC_SRC_EXT) ? (st_r.osc_en ? xin_s : pin_s)
                                                      : cps_s;
   assign ext_rise = ext_lvl && !st_r.ext_prev;
   assign ext_fall = !ext_lvl && st_r.ext_prev;
   assign ext_event = ext_rise && st_r.armed;
   assign phase_end = (st_r.phase == `GTC_PHASE_LAST);

   always_comb begin
      case (st_r.cs)
         gtc_pkg::GTC_SRC_INSTR: src_tick = phase_end;
         gtc_pkg::GTC_SRC_SYS: src_tick = 1'b1;
         default: begin
            // synchronized edges are released on the instruction boundary
            if (st_r.sync_dis) begin
               src_tick = ext_event;
            end else begin
               src_tick = phase_end && (st_r.pend || ext_event);
            end
         end
      endcase
   end

   assign gate_ok = (gate_s == st_r.gate_pol);
   assign cnt_en = st_r.run && (!st_r.gate_en || gate_ok);
   // only an unsynchronized external source keeps counting in sleep
   assign sleep_ok = !i_sleep || (ext_sel && st_r.sync_dis);
   // a count write wins over any increment in the same cycle
   assign pre_in = src_tick && cnt_en && sleep_ok && !cnt_wr;

   gtc_prescale u_pre (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_tick(pre_in),
      .i_clear(cnt_wr),
      .i_ps(st_r.ps),
      .o_tick(inc)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.phase = 2'(st_r.phase + 2'h1);
      st_nxt.ext_prev = ext_lvl;
      st_nxt.wake = 1'b0;
      // pending synchronized edge waits for the boundary
      if (st_r.sync_dis || !ext_sel || phase_end || cnt_wr) begin
         st_nxt.pend = 1'b0;
      end else if (ext_event && cnt_en) begin
         st_nxt.pend = 1'b1;
      end
      // a falling edge must be seen again after a write or a disable
      if (cnt_wr || !st_r.run) begin
         st_nxt.armed = 1'b0;
      end else if (ext_fall) begin
         st_nxt.armed = 1'b1;
      end
      if (inc) begin
         st_nxt.cnt = 16'(st_r.cnt + 16'h1);
         if (st_r.cnt == `GTC_CNT_MAX) begin
            st_nxt.wake = i_sleep;
         end
      end
      // apb answer
      st_nxt.pready = psel && penable && !st_r.pready;
      if (psel && penable && !st_r.pready) begin
         st_nxt.prdata = pwrite ? 32'h0 : rd_val;
         st_nxt.pslverr = !mapped;
      end else begin
         st_nxt.pslverr = 1'b0;
      end
      if (wr_acc) begin
         case (paddr)
            `GTC_OFF_CTRL: begin
               st_nxt.run = pwdata[`GTC_CTRL_RUN];
               st_nxt.sync_dis = pwdata[`GTC_CTRL_SYNC_DIS];
               st_nxt.osc_en = pwdata[`GTC_CTRL_OSC_EN];
               st_nxt.ps = pwdata[`GTC_CTRL_PS_LO +: 2];
               st_nxt.cs = gtc_pkg::gtc_src_t'(pwdata[`GTC_CTRL_CS_LO +: 2]);
            end
            `GTC_OFF_GATE: begin
               st_nxt.gate_pol = pwdata[`GTC_GATE_POL];
               st_nxt.gate_en = pwdata[`GTC_GATE_EN];
            end
            `GTC_OFF_CNT_LO: st_nxt.cnt[7:0] = pwdata[7:0];
            `GTC_OFF_CNT_HI: st_nxt.cnt[15:8] = pwdata[7:0];
            `GTC_OFF_STAT: begin
               if (pwdata[`GTC_STAT_OVF]) begin
                  st_nxt.ovf = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      // set wins over a clear in the same cycle
      if (inc && (st_r.cnt == `GTC_CNT_MAX)) begin
         st_nxt.ovf = 1'b1;
      end
      // crystal amplifier runs regardless of sleep
      st_nxt.xout = st_r.osc_en && !xin_s;
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= '0;
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign o_crystal_out_pin = st_r.xout;
   assign o_crystal_osc_on = st_r.osc_en;
   assign o_overflow_flag = st_r.ovf;
   assign o_wake = st_r.wake;
   assign o_count = st_r.cnt;

   // checks watch registered state; pin levels are seen only through the synchronizer
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);

   sequence s_sys_free;
      st_r.run && !st_r.gate_en && (st_r.cs == gtc_pkg::GTC_SRC_SYS) && (st_r.ps == 2'h0)
         && !i_sleep && i_ce && !cnt_wr;
   endsequence

   a_sys_four_counts:
   assert property (s_sys_free [*4] |=> (st_r.cnt == 16'($past(st_r.cnt, 4) + 16'h4)))
   else $error("system clock source did not give four counts");

   a_low_byte_write:
   assert property ((i_ce && wr_lo) |=> (st_r.cnt[7:0] == $past(pwdata[7:0])))
   else $error("low count byte write not applied");

   a_high_byte_write:
   assert property ((i_ce && wr_hi) |=> (st_r.cnt[15:8] == $past(pwdata[7:0])))
   else $error("high count byte write not applied");

   a_run_off_hold:
   assert property ((i_ce && !st_r.run && !cnt_wr) |=> $stable(st_r.cnt))
   else $error("counter moved while run bit clear");

   a_gate_mismatch_hold:
   assert property ((i_ce && st_r.gate_en && !gate_ok && !cnt_wr) |=> $stable(st_r.cnt))
   else $error("counter moved while gate closed");

   a_rollover_flag:
   assert property ((i_ce && inc && (st_r.cnt == `GTC_CNT_MAX))
                    |=> (st_r.ovf && (st_r.cnt == `GTC_CNT_RST)))
   else $error("rollover did not set overflow flag");

   a_instr_boundary:
   assert property ((inc && (st_r.cs == gtc_pkg::GTC_SRC_INSTR)) |-> phase_end)
   else $error("instruction clock count off boundary");

   a_arm_after_write:
   assert property ((i_ce && cnt_wr) |=> !st_r.armed)
   else $error("write did not demand a new falling edge");

   a_ext_needs_arm:
   assert property ((inc && ext_sel && st_r.sync_dis) |-> st_r.armed)
   else $error("external count without prior falling edge");

   a_sleep_hold:
   assert property ((i_ce && i_sleep && !(ext_sel && st_r.sync_dis) && !cnt_wr)
                    |=> $stable(st_r.cnt))
   else $error("counter ran in sleep without async external source");

   a_apb_wait:
   assert property ((psel && penable && !pready && i_ce) |=> pready)
   else $error("apb access not answered after one wait state");

   a_sync_boundary:
   assert property ((inc && ext_sel && !st_r.sync_dis) |-> phase_end)
   else $error("synchronized external count off boundary");

   a_wake_on_roll:
   assert property ((i_ce && inc && (st_r.cnt == `GTC_CNT_MAX) && i_sleep)
                    |=> st_r.wake)
   else $error("rollover in sleep gave no wake pulse");

   a_wake_single:
   assert property ((i_ce && st_r.wake) |=> !st_r.wake)
   else $error("wake pulse longer than one cycle");

   a_ovf_sticky:
   assert property ((i_ce && st_r.ovf && !(wr_acc && (paddr == `GTC_OFF_STAT)
                    && pwdata[`GTC_STAT_OVF])) |=> st_r.ovf)
   else $error("overflow flag dropped without a clear");

   // a jump of more than one would mean two increment paths fired together
   a_count_step:
   assert property ((i_ce && !cnt_wr)
                    |=> ((st_r.cnt == $past(st_r.cnt))
                         || (st_r.cnt == 16'($past(st_r.cnt) + 16'h1))))
   else $error("counter moved by more than one");

   a_disarm_off:
   assert property ((i_ce && !st_r.run) |=> !st_r.armed)
   else $error("edge stayed armed while run bit clear");
endmodule

// ==== dv/gtc_partner.sv ====
`timescale 1ns/1ps
// far-side clock sources: counter pin and sensing oscillator pulsed with a period of 16 system clocks, the crystal swinging with a period of 12
module gtc_partner (
   input wire logic i_mclk,
   input wire logic i_osc_on,
   output logic o_ext_clock_pin,
   output logic o_cps_osc,
   output logic o_crystal_in_pin
);
   int ph;
   initial begin
      o_ext_clock_pin = 1'b0;
      o_cps_osc = 1'b0;
      o_crystal_in_pin = 1'b0;
      ph = 0;
   end
   // a level is held for 8 system clocks, slow enough for the instruction alignment
   task automatic drive(input bit sel, input logic v);
      @(posedge i_mclk);
      if (sel) begin
         o_cps_osc <= v;
      end else begin
         o_ext_clock_pin <= v;
      end
      repeat (7) @(posedge i_mclk);
   endtask
   // low then high n times, then low again, so the source stands still outside a burst
   task automatic pulses(input bit sel, input int n);
      repeat (n) begin
         drive(sel, 1'b0);
         drive(sel, 1'b1);
      end
      drive(sel, 1'b0);
   endtask
   // the crystal only swings while its amplifier is on
   always @(posedge i_mclk) begin
      ph <= (ph == 5) ? 0 : ph + 1;
      if (!i_osc_on) begin
         o_crystal_in_pin <= 1'b0;
      end else if (ph == 5) begin
         o_crystal_in_pin <= ~o_crystal_in_pin;
      end
   end
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "gtc_defines.svh"
module testbench;
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [`GTC_ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic i_gate_input = 1'b0;
   logic i_sleep = 1'b0;
   logic ce = 1'b1;
   logic [31:0] prdata, q;
   logic pready, pslverr, e, ext_pin, cps, xin, xout, osc_on, ovf, wake;
   logic [15:0] o_count, d;
   int fails = 0;
   int compares = 0;
   int wakes = 0;
   int w0;
   int lat [3];

   always #5 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      if (wake === 1'b1) begin
         wakes <= wakes + 1;
      end
   end

   gtc_timer i_gtc_timer (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .i_ext_clock_pin(ext_pin), .i_cps_osc(cps),
      .i_crystal_in_pin(xin), .i_gate_input(i_gate_input), .i_sleep(i_sleep),
      .o_crystal_out_pin(xout), .o_crystal_osc_on(osc_on), .o_overflow_flag(ovf),
      .o_wake(wake), .o_count(o_count));
   gtc_partner i_gtc_partner (.i_mclk(i_mclk), .i_osc_on(osc_on), .o_ext_clock_pin(ext_pin),
      .o_cps_osc(cps), .o_crystal_in_pin(xin));

   task automatic wrap_up();
      if (fails == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      int n;
      @(posedge i_mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge i_mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fails++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // count advance over a window; only steady-state windows give exact figures
   task automatic span(input int n);
      logic [15:0] c0;
      // let the edge that ended the last access land before taking the start value
      @(posedge i_mclk);
      c0 = o_count;
      repeat (n) @(posedge i_mclk);
      d = o_count - c0;
   endtask
   function automatic logic [31:0] cv(input logic [1:0] cs, ps, input logic osc, sd, run);
      return 32'(cs) << `GTC_CTRL_CS_LO | 32'(ps) << `GTC_CTRL_PS_LO
         | 32'(osc) << `GTC_CTRL_OSC_EN | 32'(sd) << `GTC_CTRL_SYNC_DIS | 32'(run);
   endfunction

   initial begin
      repeat (100000) @(posedge i_mclk);
      fails++;
      wrap_up();
   end

   initial begin
      repeat (5) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      @(posedge i_mclk);
      check(o_count, 0, "count after reset");
      check(ovf, 0, "flag after reset");
      check(xout, 0, "amplifier idle");
      rd(`GTC_OFF_CTRL);
      check(q, 0, "control after reset");
      rd(12'h020);
      check({q[30:0], e}, 1, "unmapped read");
      wr(`GTC_OFF_CNT_LO, 32'h5a);
      wr(`GTC_OFF_CNT_HI, 32'ha5);
      repeat (2) @(posedge i_mclk);
      check(o_count, 16'ha55a, "count after byte writes");
      rd(`GTC_OFF_CNT_HI);
      check(q, 32'ha5, "high byte read");
      for (int i = 0; i < 8; i++) begin
         wr(`GTC_OFF_CTRL, cv(i < 4 ? 2'h1 : 2'h0, i[1:0], 1'b0, 1'b0, 1'b1));
         repeat (10) @(posedge i_mclk);
         span(64);
         check(d, (i < 4 ? 64 : 16) >> i[1:0], "internal rate");
      end
      wr(`GTC_OFF_CTRL, cv(2'h1, 2'h0, 1'b0, 1'b0, 1'b0));
      span(32);
      check(d, 0, "run off");
      wr(`GTC_OFF_CTRL, cv(2'h1, 2'h0, 1'b0, 1'b0, 1'b1));
      ce <= 1'b0;
      span(32);
      check(d, 0, "clock enable low");
      ce <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         i_gate_input <= i[0];
         wr(`GTC_OFF_GATE, 32'(i[2]) << `GTC_GATE_EN | 32'(i[1]) << `GTC_GATE_POL);
         repeat (6) @(posedge i_mclk);
         span(32);
         check(d, (!i[2] || i[1] == i[0]) ? 32 : 0, "gated count");
         rd(`GTC_OFF_GATE);
         check(q[`GTC_GATE_VAL], i[0], "gate level");
      end
      wr(`GTC_OFF_GATE, 0);
      // divide by 8; a prescaler that is not cleared would give differing delays
      wr(`GTC_OFF_CTRL, cv(2'h1, 2'h3, 1'b0, 1'b0, 1'b1));
      for (int k = 0; k < 3; k++) begin
         repeat (k + 1) @(posedge i_mclk);
         wr(`GTC_OFF_CNT_LO, 32'h00);
         @(posedge i_mclk);
         lat[k] = 0;
         while (o_count[7:0] == 8'h00 && lat[k] < 20) begin
            @(posedge i_mclk);
            lat[k]++;
         end
         check(lat[k], 8, "prescaler cleared by write");
      end
      // pin low before run: the first rise lacks a preceding fall and is not counted
      for (int i = 0; i < 4; i++) begin
         wr(`GTC_OFF_CTRL, 0);
         i_sleep <= i[1];
         wr(`GTC_OFF_CNT_LO, 32'hfe);
         wr(`GTC_OFF_CNT_HI, 32'hff);
         w0 = wakes;
         wr(`GTC_OFF_CTRL, cv(2'h2, 2'h0, 1'b0, i[0], 1'b1));
         i_gtc_partner.pulses(1'b0, 3);
         repeat (4) @(posedge i_mclk);
         check(o_count, i == 2 ? 16'hfffe : 16'h0000, "pin count");
         check(wakes - w0, i == 3, "wake pulses");
      end
      i_sleep <= 1'b0;
      wr(`GTC_OFF_CTRL, 0);
      i_gtc_partner.drive(1'b1, 1'b1);
      wr(`GTC_OFF_CNT_LO, 0);
      wr(`GTC_OFF_CNT_HI, 0);
      wr(`GTC_OFF_CTRL, cv(2'h3, 2'h0, 1'b0, 1'b0, 1'b1));
      i_gtc_partner.pulses(1'b1, 3);
      repeat (4) @(posedge i_mclk);
      check(o_count, 3, "sensing oscillator count");
      wr(`GTC_OFF_CTRL, 0);
      wr(`GTC_OFF_STAT, 1);
      @(posedge i_mclk);
      check(ovf, 0, "flag cleared");
      wr(`GTC_OFF_CNT_LO, 32'hff);
      wr(`GTC_OFF_CNT_HI, 32'hff);
      wr(`GTC_OFF_CTRL, cv(2'h1, 2'h0, 1'b0, 1'b0, 1'b1));
      repeat (4) @(posedge i_mclk);
      wr(`GTC_OFF_CTRL, 0);
      check(ovf, 1, "flag on rollover");
      rd(`GTC_OFF_STAT);
      check(q, 1, "status flag");
      wr(`GTC_OFF_STAT, 1);
      rd(`GTC_OFF_STAT);
      check(q, 0, "status cleared");
      wr(`GTC_OFF_CTRL, cv(2'h2, 2'h0, 1'b1, 1'b0, 1'b0));
      repeat (2) @(posedge i_mclk);
      check(osc_on, 1, "oscillator on");
      repeat (40) @(posedge i_mclk);
      wr(`GTC_OFF_CNT_LO, 0);
      wr(`GTC_OFF_CNT_HI, 0);
      wr(`GTC_OFF_CTRL, cv(2'h2, 2'h0, 1'b1, 1'b1, 1'b1));
      repeat (60) @(posedge i_mclk);
      check(o_count != 0 && o_count <= 6, 1, "crystal count");
      // catch a fresh rise of the crystal input, then the amplifier must drive low
      w0 = 0;
      while (xin === 1'b1 && w0 < 20) begin
         @(posedge i_mclk);
         w0++;
      end
      while (xin !== 1'b1 && w0 < 20) begin
         @(posedge i_mclk);
         w0++;
      end
      check(w0 < 20, 1, "crystal swing");
      repeat (4) @(posedge i_mclk);
      check(xout, 0, "amplifier drive");
      wrap_up();
   end
endmodule
